// File: sim/cpu_sideband_cache_control_tb.sv
module cpu_sideband_cache_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import csb_pkg::*;
    logic sys_clk, rst_b, mode, cfg_wr, psel, penable, pwrite, pready, er;
    logic fp_error, m_pres, m_strap, t_begin, t_dirty, pslverr;
    logic d_begin, d_dirty, d_active;
    logic [7:0] cfg_idx, cfg_wdata, cfg_rdata, paddr;
    logic [31:0] pwdata, prdata, rd;
    int miscompares, n_checks;
    csb_if csb_if_inst ();
    wire ign_n = csb_if_inst.ignore_fp_error_out_n;
    wire cache_n = csb_if_inst.cacheable_cycle_out_n;
    wire pin_n = csb_if_inst.sys_mgmt_interrupt_out_n;
    csb_dev csb_dev_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .smm_flush_mode(mode), .cfg_wr(cfg_wr), .cfg_idx(cfg_idx),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .module_cycle_begin(d_begin), .module_dirty_hit(d_dirty),
        .module_active(d_active), .pins(csb_if_inst));
    csb_cpu csb_cpu_inst (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fp_error(fp_error), .module_present(m_pres),
        .module_strap(m_strap), .module_cycle_begin(t_begin),
        .module_dirty_hit(t_dirty), .pins(csb_if_inst));
    csb_assertions csb_assertions_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .smm_flush_mode(mode),
        .coproc_error_in_n(csb_if_inst.coproc_error_in_n),
        .ignore_fp_error_out_n(ign_n), .cacheable_cycle_out_n(cache_n),
        .sys_mgmt_interrupt_out_n(pin_n), .io_write(csb_if_inst.io_write),
        .io_port(csb_if_inst.io_port), .smm_enter(csb_if_inst.smm_enter),
        .green_wake(csb_if_inst.green_wake), .rom_write(csb_if_inst.rom_write),
        .cpu_cycle(csb_if_inst.cpu_cycle),
        .cycle_cacheable(csb_if_inst.cycle_cacheable));
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input int d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic cfg(input logic [7:0] i, input logic [7:0] d);
        cfg_wr <= 1'h1;
        cfg_idx <= i;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_wr <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rst(input logic s, input logic p);
        rst_b <= 1'h0;
        m_strap <= s;
        m_pres <= p;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic t_ignore();
        fp_error <= 1'h1;
        repeat (3) @(posedge sys_clk);
        fp_error <= 1'h0;
        apb(1'h1, OFF_IOPORT, 32'h0000_00f1);
        apb(1'h1, OFF_CTRL, 32'h0000_0010);
        @(posedge sys_clk);
        chk(ign_n, 1'h0);
        apb(1'h0, OFF_STAT, 0);
        chk(rd[0], 1'h1);
        apb(1'h1, OFF_IOPORT, 32'h0000_00f0);
        apb(1'h1, OFF_CTRL, 32'h0000_0010);
        @(posedge sys_clk);
        chk(ign_n, 1'h1);
    endtask
    task automatic pin_cnt(input int b, input logic md, input int exp);
        int c;
        mode <= md;
        repeat (4) @(posedge sys_clk);
        apb(1'h1, OFF_CTRL, 32'h1 << b);
        c = 0;
        repeat (10) begin
            @(posedge sys_clk);
            c += int'(pin_n === 1'h0);
        end
        chk(c, exp);
    endtask
    task automatic t_mod(input logic s, input logic p, input logic [7:0] l1);
        rst(s, p);
        chk(ign_n, 1'h1);
        cfg(IDX_MOD_CFG, 8'h02);
        cfg(IDX_L1_CFG, l1);
        cfg_idx <= IDX_MOD_STAT;
        m_strap <= !s;
        t_begin <= 1'h1;
        t_dirty <= 1'h1;
        repeat (4) @(posedge sys_clk);
        chk(cfg_rdata[BIT_MOD_PRESENT], s & p);
        chk(d_active, s & ~l1[BIT_L1_WT]);
        chk({d_begin, d_dirty}, {s, s});
        t_begin <= 1'h0;
        t_dirty <= 1'h0;
    endtask
    initial begin
        {rst_b, mode, cfg_wr, psel, penable, pwrite, fp_error} = '0;
        {t_begin, t_dirty, cfg_idx, cfg_wdata, paddr, pwdata} = '0;
        rst(1'h1, 1'h1);
        t_ignore();
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, OFF_CTRL, i << CTRL_CACHEABLE);
            @(posedge sys_clk);
            chk(cache_n, i != 3);
        end
        pin_cnt(CTRL_SMM_ENTER, 1'h0, 1);
        pin_cnt(CTRL_ROM_WRITE, 1'h0, 0);
        pin_cnt(CTRL_GREEN_WAKE, 1'h0, 0);
        for (int b = 1; b < 4; b++) begin
            pin_cnt(b, 1'h1, FLUSH_CYCLES);
        end
        apb(1'h0, 8'h0c, 0);
        chk(er, 1'h1);
        fp_error <= 1'h1;
        repeat (3) @(posedge sys_clk);
        fp_error <= 1'h0;
        t_mod(1'h1, 1'h1, 8'h00);
        t_mod(1'h1, 1'h0, 8'h04);
        t_mod(1'h0, 1'h1, 8'h00);
        tally_and_finish();
    end
    initial begin
        #200us;
        miscompares++;
        tally_and_finish();
    end
endmodule // cpu_sideband_cache_control_tb

// File: sim/csb_assertions.sv
module csb_assertions (
    input logic        sys_clk,
    input logic        rst_b,
    input logic        smm_flush_mode,
    input logic        coproc_error_in_n,
    input logic        ignore_fp_error_out_n,
    input logic        cacheable_cycle_out_n,
    input logic        sys_mgmt_interrupt_out_n,
    input logic        io_write,
    input logic [15:0] io_port,
    input logic        smm_enter,
    input logic        green_wake,
    input logic        rom_write,
    input logic        cpu_cycle,
    input logic        cycle_cacheable
);
    import csb_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic clr;
    logic ev;
    assign clr = io_write && io_port == PORT_FP_CLEAR;
    assign ev = smm_enter || green_wake || rom_write;
    a_ignore_set: assert property (
        !coproc_error_in_n |=> !ignore_fp_error_out_n) else $error("no set");
    a_ignore_hold: assert property (
        !ignore_fp_error_out_n && !clr |=> !ignore_fp_error_out_n)
        else $error("ignore dropped");
    a_ignore_clear: assert property (
        clr && coproc_error_in_n |=> ignore_fp_error_out_n)
        else $error("no clear");
    a_ignore_cause: assert property (
        $fell(ignore_fp_error_out_n) |-> $past(!coproc_error_in_n))
        else $error("ignore without error");
    a_cache_only: assert property (
        !cacheable_cycle_out_n |-> cpu_cycle && cycle_cacheable
        || $past(cpu_cycle && cycle_cacheable)) else $error("bad cacheable");
    a_intr_only: assert property (
        !smm_flush_mode && !smm_enter |=> sys_mgmt_interrupt_out_n)
        else $error("pin low in interrupt style");
    a_flush_len: assert property (
        smm_flush_mode && ev |=> !sys_mgmt_interrupt_out_n [*4])
        else $error("flush too short");
    a_pin_cause: assert property (
        $fell(sys_mgmt_interrupt_out_n)
        |-> $past(smm_flush_mode ? ev : smm_enter)) else $error("stray pin");
    c_flush: cover property (smm_flush_mode && rom_write);
    c_intr: cover property (!smm_flush_mode && smm_enter);
    c_clear: cover property (clr && !ignore_fp_error_out_n);
endmodule // csb_assertions

// File: verilog/csb_cpu.sv
module csb_cpu (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fp_error,
    input  wire logic        module_present,
    input  wire logic        module_strap,
    input  wire logic        module_cycle_begin,
    input  wire logic        module_dirty_hit,
    csb_if.cpu               pins
);
    import csb_pkg::*;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] port;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        fp_err;
        logic        mcb;
        logic        mdh;
    } csb_cpu_s;

    csb_cpu_s st_ff;
    csb_cpu_s nxt_st;
    logic       acc;
    logic       done;
    logic [2:0] stat;

    always_comb begin
        nxt_st = st_ff;
        acc  = psel & penable & ~st_ff.ready;
        done = psel & penable & st_ff.ready;
        stat = {~pins.sys_mgmt_interrupt_out_n,
                ~pins.cacheable_cycle_out_n,
                ~pins.ignore_fp_error_out_n};
        nxt_st.ready = acc;
        nxt_st.err   = 1'b0;
        nxt_st.rdata = 32'h0000_0000;
        // Strobe bits self-clear after one cycle
        nxt_st.ctrl[CTRL_SMM_ENTER]  = 1'b0;
        nxt_st.ctrl[CTRL_GREEN_WAKE] = 1'b0;
        nxt_st.ctrl[CTRL_ROM_WRITE]  = 1'b0;
        nxt_st.ctrl[CTRL_IO_WRITE]   = 1'b0;
        if (acc) begin
            unique case (paddr)
                OFF_CTRL:   nxt_st.rdata = st_ff.ctrl;
                OFF_STAT:   nxt_st.rdata = {29'h0, stat};
                OFF_IOPORT: nxt_st.rdata = {16'h0000, st_ff.port};
                default:    nxt_st.err   = 1'b1;
            endcase
        end
        // Writes land at the edge that completes the transfer
        if (done && pwrite) begin
            if (paddr == OFF_CTRL) nxt_st.ctrl = pwdata;
            if (paddr == OFF_IOPORT) nxt_st.port = pwdata[15:0];
        end
        nxt_st.fp_err = fp_error;
        nxt_st.mcb  = module_cycle_begin;
        nxt_st.mdh  = module_dirty_hit;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff      <= '0;
            st_ff.ctrl <= CTRL_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata  = st_ff.rdata;
    assign pready  = st_ff.ready;
    assign pslverr = st_ff.err;
    assign pins.coproc_error_in_n       = ~st_ff.fp_err;
    assign pins.module_cycle_begin_in_n = ~st_ff.mcb;
    assign pins.module_dirty_hit_in_n   = ~st_ff.mdh;
    assign pins.module_present_in_n     = ~module_present;
    assign pins.module_mode_strap_n     = ~module_strap;
    assign pins.io_write        = st_ff.ctrl[CTRL_IO_WRITE];
    assign pins.io_port         = st_ff.port;
    assign pins.smm_enter       = st_ff.ctrl[CTRL_SMM_ENTER];
    assign pins.green_wake      = st_ff.ctrl[CTRL_GREEN_WAKE];
    assign pins.rom_write       = st_ff.ctrl[CTRL_ROM_WRITE];
    assign pins.cpu_cycle       = st_ff.ctrl[CTRL_CYCLE];
    assign pins.cycle_cacheable = st_ff.ctrl[CTRL_CACHEABLE];
endmodule // csb_cpu

// File: verilog/csb_dev.sv
// Function
// - CPU drives error input on FP error
// - Ignore-error output latches active on error
// - Port F0h write or reset clears it
// - Cacheable output only for cacheable cycles
// - First SMM style: pin is interrupt only
// - Flush before SMM and green wake
// - Flush on writes to protected ROM
// - Module cycle-begin is input only
// - Module dirty-hit is input only
// - Present captured at reset, index 3Ch bit 7
// - Software sets 3Ah[1], keeps 27h[2] low
// - Module pins inputs only when strap low
//
// The address map and the APB register port were decided locally.
module csb_dev (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       smm_flush_mode,
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_idx,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    output logic            module_cycle_begin,
    output logic            module_dirty_hit,
    output logic            module_active,
    csb_if.dev              pins
);
    import csb_pkg::*;

    typedef struct packed {
        logic       ign;
        logic       cache_ok;
        logic       pin_act;
        logic [3:0] fl_cnt;
        logic       strap_done;
        logic       mod_sel;
        logic       present;
        logic [7:0] mod_cfg;
        logic [7:0] l1_cfg;
        logic [7:0] rdata;
        logic       mcb;
        logic       mdh;
        logic       mact;
    } csb_dev_s;

    csb_dev_s st_ff;
    csb_dev_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!st_ff.strap_done) begin
            nxt_st.strap_done = 1'b1;
            nxt_st.mod_sel    = ~pins.module_mode_strap_n;
            nxt_st.present    = ~pins.module_present_in_n &
                                ~pins.module_mode_strap_n;
        end
        if (!pins.coproc_error_in_n) begin
            nxt_st.ign = 1'b1;
        end else if (pins.io_write && pins.io_port == PORT_FP_CLEAR) begin
            nxt_st.ign = 1'b0;
        end
        nxt_st.cache_ok = pins.cpu_cycle & pins.cycle_cacheable;
        if (st_ff.fl_cnt != 4'h0) begin
            nxt_st.fl_cnt = st_ff.fl_cnt - 4'h1;
        end
        if (smm_flush_mode) begin
            // flush on SMM entry, green wake and ROM write
            if (pins.smm_enter || pins.green_wake || pins.rom_write) begin
                nxt_st.fl_cnt = FLUSH_CYCLES;
            end
            nxt_st.pin_act = (nxt_st.fl_cnt != 4'h0);
        end else begin
            nxt_st.fl_cnt = 4'h0;
            nxt_st.pin_act = pins.smm_enter;
        end
        if (cfg_wr && cfg_idx == IDX_MOD_CFG) begin
            nxt_st.mod_cfg = cfg_wdata;
        end
        if (cfg_wr && cfg_idx == IDX_L1_CFG) begin
            nxt_st.l1_cfg = cfg_wdata;
        end
        unique case (cfg_idx)
            IDX_MOD_CFG: nxt_st.rdata = st_ff.mod_cfg;
            IDX_L1_CFG:  nxt_st.rdata = st_ff.l1_cfg;
            IDX_MOD_STAT: begin
                nxt_st.rdata = 8'h00;
                nxt_st.rdata[BIT_MOD_PRESENT] = st_ff.present;
            end
            default:     nxt_st.rdata = 8'h00;
        endcase
        // active only when enabled and L1 write-back
        nxt_st.mact = st_ff.mod_sel & st_ff.mod_cfg[BIT_MOD_ENABLE] &
                      ~st_ff.l1_cfg[BIT_L1_WT];
        nxt_st.mcb = st_ff.mod_sel & ~pins.module_cycle_begin_in_n;
        nxt_st.mdh = st_ff.mod_sel & ~pins.module_dirty_hit_in_n;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff         <= '0;
            st_ff.mod_cfg <= CFG_RESET;
            st_ff.l1_cfg  <= CFG_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pins.ignore_fp_error_out_n    = ~st_ff.ign;
    assign pins.cacheable_cycle_out_n    = ~st_ff.cache_ok;
    assign pins.sys_mgmt_interrupt_out_n = ~st_ff.pin_act;
    assign cfg_rdata          = st_ff.rdata;
    assign module_cycle_begin = st_ff.mcb;
    assign module_dirty_hit   = st_ff.mdh;
    assign module_active      = st_ff.mact;
endmodule // csb_dev

// File: verilog/csb_if.sv
interface csb_if;
    logic       coproc_error_in_n;
    logic       ignore_fp_error_out_n;
    logic       cacheable_cycle_out_n;
    logic       sys_mgmt_interrupt_out_n;
    logic       module_cycle_begin_in_n;
    logic       module_dirty_hit_in_n;
    logic       module_present_in_n;
    logic       module_mode_strap_n;
    logic       io_write;
    logic [15:0] io_port;
    logic       smm_enter;
    logic       green_wake;
    logic       rom_write;
    logic       cpu_cycle;
    logic       cycle_cacheable;

    modport dev (
        input  coproc_error_in_n, module_cycle_begin_in_n,
        input  module_dirty_hit_in_n, module_present_in_n,
        input  module_mode_strap_n, io_write, io_port, smm_enter,
        input  green_wake, rom_write, cpu_cycle, cycle_cacheable,
        output ignore_fp_error_out_n, cacheable_cycle_out_n,
        output sys_mgmt_interrupt_out_n
    );
    modport cpu (
        output coproc_error_in_n, module_cycle_begin_in_n,
        output module_dirty_hit_in_n, module_present_in_n,
        output module_mode_strap_n, io_write, io_port, smm_enter,
        output green_wake, rom_write, cpu_cycle, cycle_cacheable,
        input  ignore_fp_error_out_n, cacheable_cycle_out_n,
        input  sys_mgmt_interrupt_out_n
    );
endinterface

// File: verilog/csb_pkg.sv
package csb_pkg;
    // Configuration register indices
    localparam logic [7:0]  IDX_MOD_CFG      = 8'h3a;
    localparam logic [7:0]  IDX_L1_CFG       = 8'h27;
    localparam logic [7:0]  IDX_MOD_STAT     = 8'h3c;
    localparam int          BIT_MOD_ENABLE   = 1;
    localparam int          BIT_L1_WT        = 2;
    localparam int          BIT_MOD_PRESENT  = 7;
    localparam logic [7:0]  CFG_RESET        = 8'h00;
    // I/O port that clears the error-ignore latch
    localparam logic [15:0] PORT_FP_CLEAR    = 16'h00f0;
    // Flush pulse length in sys_clk cycles
    localparam logic [3:0]  FLUSH_CYCLES     = 4'h4;
    // Controller register offsets on APB
    localparam logic [7:0]  OFF_CTRL         = 8'h00;
    localparam logic [7:0]  OFF_STAT         = 8'h04;
    localparam logic [7:0]  OFF_IOPORT       = 8'h08;
    // Control register field positions
    localparam int          CTRL_SMM_FLUSH   = 0;
    localparam int          CTRL_SMM_ENTER   = 1;
    localparam int          CTRL_GREEN_WAKE  = 2;
    localparam int          CTRL_ROM_WRITE   = 3;
    localparam int          CTRL_IO_WRITE    = 4;
    localparam int          CTRL_CACHEABLE   = 5;
    localparam int          CTRL_CYCLE       = 6;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
endpackage
